// [design/tgsp_top.sv]
// Timer gate control with single-pulse and toggle modes, Wishbone registers.
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tgsp_top (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // Gate source and count clock enable from outside
   input  wire logic        gate_pin_i,
   input  wire logic        inc_tick_i,
   // Status outputs
   output logic             count_enable_o,
   output logic             irq_o
);
   typedef struct packed {
      logic [31:0]                    dat;
      logic                           ack;
      logic                           timer_on;
      logic                           gate_en;
      logic                           gate_pol;
      logic                           toggle;
      logic                           single_pulse;
      logic                           arm_done;
      logic                           armed_live;
      logic                           gate_prev;
      logic                           toggle_ff;
      logic                           cnt_en;
      logic [1:0]                     sync_fill;
      logic [tgsp_pkg::CNT_WIDTH-1:0] count;
      logic [tgsp_pkg::IRQ_WIDTH-1:0] irq_stat;
      logic [tgsp_pkg::IRQ_WIDTH-1:0] irq_mask;
      logic                           irq;
   } tgsp_st_t;

   tgsp_st_t st_r;
   tgsp_st_t st_nxt;
   logic     gate_sync;

   tgsp_sync u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (gate_pin_i),
      .q_o   (gate_sync)
   );

   function automatic logic [31:0] ctrl_word(input tgsp_st_t s);
      logic [31:0] w;
      w = '0;
      w[tgsp_pkg::GC_TIMER_ON]     = s.timer_on;
      w[tgsp_pkg::GC_GATE_EN]      = s.gate_en;
      w[tgsp_pkg::GC_GATE_POL]     = s.gate_pol;
      w[tgsp_pkg::GC_TOGGLE]       = s.toggle;
      w[tgsp_pkg::GC_SINGLE_PULSE] = s.single_pulse;
      w[tgsp_pkg::GC_ARM_DONE]     = s.arm_done;
      w[tgsp_pkg::GC_LEVEL]        = s.gate_prev;
      return w;
   endfunction

   logic gate_lvl;
   logic gate_rise;
   logic gate_ok;
   logic ctl;
   logic ctl_prev;
   logic req;
   logic wr;
   logic rd;
   logic new_sp;
   logic [31:0] wdat;
   logic [tgsp_pkg::IRQ_WIDTH-1:0] ev;

   always_comb begin
      st_nxt = st_r;
      ev     = '0;
      req    = cyc_i && stb_i && !st_r.ack;
      wr     = req && we_i && sel_i[0];
      rd     = req && !we_i;
      wdat   = dat_i;
      new_sp = st_r.single_pulse;
      // Polarity applied after synchronising; level is tracked regardless of gate enable.
      gate_ok = (st_r.sync_fill == tgsp_pkg::SYNC_FILL);
      if (!gate_ok) begin
         st_nxt.sync_fill = st_r.sync_fill + 2'h1;
      end
      // The synchroniser leaves reset holding zeros, not the pin; the last level stands until
      // real samples arrive, so the status bit shows no false level and no false edge follows reset.
      gate_lvl  = gate_ok ? (gate_sync ^ ~st_r.gate_pol) : st_r.gate_prev;
      gate_rise = gate_lvl && !st_r.gate_prev;
      st_nxt.gate_prev = gate_lvl;

      // Toggle flip-flop flips on each active edge of the gate.
      if (st_r.toggle && gate_rise) begin
         st_nxt.toggle_ff = !st_r.toggle_ff;
      end
      ctl      = st_r.toggle ? st_r.toggle_ff : st_r.gate_prev;
      ctl_prev = ctl;
      if (st_r.toggle && gate_rise) begin
         ctl = !st_r.toggle_ff;
      end else if (!st_r.toggle) begin
         ctl = gate_lvl;
      end

      // Arm takes effect only on the next incrementing edge.
      if (st_r.arm_done && inc_tick_i) begin
         st_nxt.armed_live = 1'b1;
      end
      // Trailing edge of the control (gate or toggled period) ends capture.
      if (st_r.single_pulse && st_r.arm_done && st_r.armed_live && ctl_prev && !ctl) begin
         st_nxt.arm_done   = 1'b0;
         st_nxt.armed_live = 1'b0;
         ev[tgsp_pkg::IRQ_DONE] = 1'b1;
      end

      if (!st_r.gate_en) begin
         st_nxt.cnt_en = st_r.timer_on;
      end else if (st_r.single_pulse) begin
         // Only an armed, live capture lets the gate count.
         st_nxt.cnt_en = st_r.timer_on && st_nxt.arm_done && st_nxt.armed_live && ctl;
      end else begin
         st_nxt.cnt_en = st_r.timer_on && ctl;
      end

      if (st_r.cnt_en && inc_tick_i) begin
         st_nxt.count = st_r.count + 1'b1;
         if (st_r.count == tgsp_pkg::CNT_MAX) begin
            ev[tgsp_pkg::IRQ_OVERFLOW] = 1'b1;
         end
      end

      st_nxt.ack = req;
      st_nxt.dat = '0;
      if (wr) begin
         case (adr_i)
            tgsp_pkg::ADR_GATE_CTRL: begin
               // The level bit is never written.
               st_nxt.timer_on     = wdat[tgsp_pkg::GC_TIMER_ON];
               st_nxt.gate_en      = wdat[tgsp_pkg::GC_GATE_EN];
               st_nxt.gate_pol     = wdat[tgsp_pkg::GC_GATE_POL];
               st_nxt.toggle       = wdat[tgsp_pkg::GC_TOGGLE];
               new_sp              = wdat[tgsp_pkg::GC_SINGLE_PULSE];
               st_nxt.single_pulse = new_sp;
               if (!wdat[tgsp_pkg::GC_TOGGLE]) begin
                  st_nxt.toggle_ff = 1'b0;
               end
               if (wdat[tgsp_pkg::GC_ARM_DONE] && !st_r.arm_done) begin
                  st_nxt.arm_done   = 1'b1;
                  st_nxt.armed_live = 1'b0;
               end
            end
            tgsp_pkg::ADR_COUNT: begin
               st_nxt.count = wdat[tgsp_pkg::CNT_WIDTH-1:0];
            end
            tgsp_pkg::ADR_IRQ_MASK: begin
               st_nxt.irq_mask = wdat[tgsp_pkg::IRQ_WIDTH-1:0];
            end
            default: begin
            end
         endcase
      end
      // Arming without single-pulse enable has no effect; leaving the mode disarms.
      if (!new_sp) begin
         st_nxt.arm_done   = 1'b0;
         st_nxt.armed_live = 1'b0;
      end

      if (rd) begin
         case (adr_i)
            tgsp_pkg::ADR_GATE_CTRL: st_nxt.dat = ctrl_word(st_r);
            tgsp_pkg::ADR_COUNT:     st_nxt.dat = {16'h0000, st_r.count};
            tgsp_pkg::ADR_IRQ_STAT: begin
               st_nxt.dat      = {30'h0, st_r.irq_stat};
               st_nxt.irq_stat = '0;
            end
            tgsp_pkg::ADR_IRQ_MASK:  st_nxt.dat = {30'h0, st_r.irq_mask};
            default:                 st_nxt.dat = '0;
         endcase
      end
      // A new event in the clearing cycle survives the read clear.
      st_nxt.irq_stat = st_nxt.irq_stat | ev;
      st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_mask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dat_o          = st_r.dat;
   assign ack_o          = st_r.ack;
   assign count_enable_o = st_r.cnt_en;
   assign irq_o          = st_r.irq;
endmodule
`default_nettype wire

// [design/tgsp_pkg.sv]
// Package of constants for the timer gate single-pulse block.
package tgsp_pkg;
   // Register word offsets (byte addresses).
   localparam logic [3:0] ADR_GATE_CTRL = 4'h0;
   localparam logic [3:0] ADR_COUNT     = 4'h4;
   localparam logic [3:0] ADR_IRQ_STAT  = 4'h8;
   localparam logic [3:0] ADR_IRQ_MASK  = 4'hc;
   // Gate control register fields.
   localparam int GC_TIMER_ON      = 0;
   localparam int GC_GATE_EN       = 1;
   localparam int GC_GATE_POL      = 2;
   localparam int GC_TOGGLE        = 3;
   localparam int GC_SINGLE_PULSE  = 4;
   localparam int GC_ARM_DONE      = 5;
   localparam int GC_LEVEL         = 6;
   localparam int GC_WIDTH         = 7;
   // Interrupt status fields.
   localparam int IRQ_DONE         = 0;
   localparam int IRQ_OVERFLOW     = 1;
   localparam int IRQ_WIDTH        = 2;
   localparam int CNT_WIDTH        = 16;
   localparam logic [CNT_WIDTH-1:0] CNT_RESET = 16'h0000;
   localparam logic [CNT_WIDTH-1:0] CNT_MAX   = 16'hffff;
   // Cycles after reset before the synchronised gate holds a real pin sample.
   localparam logic [1:0]           SYNC_FILL = 2'h2;
endpackage

// [design/tgsp_sync.sv]
// Two-flop synchroniser for the external gate pin.
`timescale 1ns/1ps
`default_nettype none
module tgsp_sync (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Data
   input  wire logic d_i,
   output logic      q_o
);
   typedef struct packed {
      logic s1;
      logic s2;
   } tgsp_sync_st_t;
   tgsp_sync_st_t st_r;
   tgsp_sync_st_t st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = d_i;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q_o = st_r.s2;
endmodule
`default_nettype wire

// [test/tgsp_gate_src.sv]
// Gate source model: commanded gate pin level and periodic count ticks.
`timescale 1ns/1ps
`default_nettype none
module tgsp_gate_src (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Commanded gate level
   input  wire logic level_i,
   // Gate pin and tick
   output logic      gate_pin_o,
   output logic      inc_tick_o
);
   logic [1:0] div_r;
   // A tick every fourth cycle, so arming has to wait for a real incrementing edge.
   always_ff @(posedge clk_i) begin
      div_r      <= rst_i ? 2'h0 : div_r + 2'h1;
      inc_tick_o <= (div_r == 2'h3);
      gate_pin_o <= level_i;
   end
endmodule
`default_nettype wire

// [test/tgsp_properties.sv]
// Port checker for the timer gate block.
`timescale 1ns/1ps
`default_nettype none
module tgsp_properties (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Bus
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [31:0] dat_o,
   input  wire logic        ack_o,
   // Status
   input  wire logic        count_enable_o,
   input  wire logic        irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic rd = ack_o && !we_i;
   a_ack_reply: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
   a_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
   a_idle_zero: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data not zero");
   a_ctrl_upper: assert property (rd && adr_i == tgsp_pkg::ADR_GATE_CTRL |-> dat_o[31:7] == 25'h0)
      else $error("control upper bits set");
   a_count_upper: assert property (rd && adr_i == tgsp_pkg::ADR_COUNT |-> dat_o[31:16] == 16'h0)
      else $error("count upper bits set");
   a_stat_upper: assert property (rd && adr_i == tgsp_pkg::ADR_IRQ_STAT |-> dat_o[31:2] == 30'h0)
      else $error("status upper bits set");
   a_unmapped_zero: assert property (rd && adr_i[1:0] != 2'h0 |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_arm_needs_sp: assert property (rd && adr_i == tgsp_pkg::ADR_GATE_CTRL |->
      !dat_o[tgsp_pkg::GC_ARM_DONE] || dat_o[tgsp_pkg::GC_SINGLE_PULSE]) else $error("armed without single pulse");
   c_armed: cover property (rd && adr_i == tgsp_pkg::ADR_GATE_CTRL && dat_o[tgsp_pkg::GC_ARM_DONE]);
   c_count: cover property ($rose(count_enable_o));
   c_irq: cover property ($rose(irq_o));
endmodule
bind tgsp_top tgsp_properties u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o,
   .count_enable_o, .irq_o);
`default_nettype wire

// [test/tb_tgsp_top.sv]
// Testbench for the timer gate block: register sequences against expected values.
`timescale 1ns/1ps
`default_nettype none
module tb_tgsp_top;
   localparam logic [3:0] C = tgsp_pkg::ADR_GATE_CTRL;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [3:0]  adr_i = 4'h0;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic        lvl   = 1'b1;
   logic [31:0] dat_o;
   logic [31:0] rd;
   logic        ack_o;
   logic        gate_pin;
   logic        tick;
   logic        count_enable_o;
   logic        irq_o;
   int          error_cnt = 0;
   int          num_checks = 0;
   int          cycles = 0;
   always #4 clk_i = ~clk_i;
   tgsp_gate_src SRC (.clk_i, .rst_i, .level_i(lvl), .gate_pin_o(gate_pin), .inc_tick_o(tick));
   tgsp_top DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .gate_pin_i(gate_pin), .inc_tick_i(tick), .count_enable_o, .irq_o);
   task automatic stop_test();
      $display("Checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= 4'hf;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic rdc(input string n, input logic [3:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(n, rd, e);
   endtask
   // The gate passes two sync flops and a level flop, so settle before looking.
   task automatic gate(input logic v);
      lvl <= v;
      repeat (8) @(posedge clk_i);
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         error_cnt++;
         stop_test();
      end
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc("ctrl_reset", C, 32'h0);
      gate(1'b0);
      wb(1'b1, C, 32'h44);
      gate(1'b0);
      rdc("level_ro", C, 32'h04);
      gate(1'b1);
      rdc("level_no_gate", C, 32'h44);
      wb(1'b1, tgsp_pkg::ADR_IRQ_MASK, 32'h1);
      wb(1'b1, tgsp_pkg::ADR_COUNT, 32'habcd);
      rdc("count", tgsp_pkg::ADR_COUNT, 32'habcd);
      rdc("unmapped", 4'h2, 32'h0);
      gate(1'b0);
      wb(1'b1, C, 32'h17);
      wb(1'b1, C, 32'h37);
      rdc("armed", C, 32'h37);
      gate(1'b1);
      chk("count_en_armed", count_enable_o, 1);
      gate(1'b0);
      chk("count_en_done", count_enable_o, 0);
      rdc("done_clear", C, 32'h17);
      chk("irq_done", irq_o, 1);
      rdc("irq_stat", tgsp_pkg::ADR_IRQ_STAT, 32'h1);
      gate(1'b1);
      chk("irq_cleared", irq_o, 0);
      chk("count_en_ignored", count_enable_o, 0);
      wb(1'b1, C, 32'h37);
      wb(1'b1, C, 32'h07);
      rdc("sp_off_clears_arm", C, 32'h47);
      gate(1'b0);
      wb(1'b1, C, 32'h1f);
      wb(1'b1, C, 32'h3f);
      gate(1'b1);
      chk("toggle_first", count_enable_o, 1);
      gate(1'b0);
      chk("toggle_low_half", count_enable_o, 1);
      gate(1'b1);
      chk("toggle_period_end", count_enable_o, 0);
      rdc("toggle_done", C, 32'h5f);
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("irq_after_reset", irq_o, 0);
      chk("count_en_after_reset", count_enable_o, 0);
      rdc("ctrl_after_reset", C, 32'h0);
      stop_test();
   end
endmodule
`default_nettype wire
